// ---- rtl/dps_defines.vh ----
`ifndef DPS_DEFINES_VH
`define DPS_DEFINES_VH

// ----------------------------------------
// Status word field positions
// ----------------------------------------
`define DPS_ST_ERASE_ACK      0
`define DPS_ST_FLASH_READY    1
`define DPS_ST_SECURED        2
`define DPS_ST_OUT_OF_RESET   3
`define DPS_ST_RESERVED4      4
`define DPS_ST_ERASE_ENABLE   5
`define DPS_ST_BACKDOOR_EN    6
`define DPS_ST_LP_STOP_SEL    7
`define DPS_ST_VLP_MODE       8
`define DPS_ST_WIDTH          32

// ----------------------------------------
// Control word field positions
// ----------------------------------------
`define DPS_CT_ERASE_IN_PROG  0

// ----------------------------------------
// Register indices (request address bits 3:2)
// ----------------------------------------
`define DPS_IDX_STATUS        2'h0
`define DPS_IDX_CONTROL       2'h1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DPS_RST_CONTROL       32'h00000000
`define DPS_RST_ERASE_ACK     1'h0

// ----------------------------------------
// Stop mode select encodings
// ----------------------------------------
`define DPS_STOPM_VERY_LOW_POWER_STOP        3'h2
`define DPS_STOPM_LLS         3'h3
`define DPS_STOPM_VLLS        3'h4

// ----------------------------------------
// Serial link framing
// ----------------------------------------
`define DPS_REQ_BITS          4'h8
`define DPS_ACK_BITS          6'h03
`define DPS_DATA_BITS         6'h20
`define DPS_ACK_OK            3'h1

`endif

// ---- rtl/dps_sync.v ----
`timescale 1ns/10ps
`default_nettype none

module dps_sync #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             reset,
   // Asynchronous in, synchronous out
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_reg;

   // ----------------------------------------
   // Two stages; first stage feeds only the second
   // ----------------------------------------
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         meta_reg <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

`default_nettype wire

// ---- rtl/dps_erase_ctl.v ----
`timescale 1ns/10ps
`default_nettype none
`include "dps_defines.vh"

module dps_erase_ctl (
   // Clock and reset
   input  wire clk_sys,
   input  wire reset,
   // System state
   input  wire sys_reset_active,
   input  wire erase_permitted,
   // Debugger control write
   input  wire ctrl_write,
   input  wire ctrl_erase_bit,
   // Flash controller handshake
   input  wire flash_erase_started,
   input  wire flash_erase_done,
   output reg  erase_in_progress_reg,
   output reg  erase_ack_reg,
   output reg  flash_erase_req_reg
);

   wire launch;
   wire ack_set;
   reg  erase_in_progress_next;
   reg  erase_ack_next;

   assign launch  = ctrl_write & ctrl_erase_bit & ~erase_in_progress_reg;
   // Refused erase never acknowledges; bit then waits for system reset
   assign ack_set = flash_erase_started & erase_in_progress_reg & erase_permitted;

   // ----------------------------------------
   // Next state; a set always wins over a clear
   // ----------------------------------------
   always @* begin
      erase_in_progress_next = erase_in_progress_reg;
      if (launch) begin
         erase_in_progress_next = 1'b1;
      end else if (flash_erase_done | sys_reset_active) begin
         erase_in_progress_next = 1'b0;
      end
      erase_ack_next = erase_ack_reg;
      if (ack_set) begin
         erase_ack_next = 1'b1;
      end else if (sys_reset_active) begin
         erase_ack_next = 1'b0;
      end else if (launch) begin
         erase_ack_next = 1'b0;
      end
   end

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         erase_in_progress_reg <= 1'b0;
         erase_ack_reg         <= `DPS_RST_ERASE_ACK;
         flash_erase_req_reg   <= 1'b0;
      end else begin
         erase_in_progress_reg <= erase_in_progress_next;
         erase_ack_reg         <= erase_ack_next;
         flash_erase_req_reg   <= erase_in_progress_next & erase_permitted;
      end
   end

endmodule

`default_nettype wire

// ---- rtl/dps_status_port.v ----
`timescale 1ns/10ps
`default_nettype none
`include "dps_defines.vh"

// Functional notes
// - Erase acknowledge flag clears on system reset; an erase start in the same cycle sets it instead.
// - Launching an erase by writing the erase bit clears the acknowledge.
// - Acknowledge sets only once flash has started the erase.
// - Disabled mass erase never acknowledges and never reaches flash.
// - Flash ready shows initialisation done, even with system held in reset.
// - Bit 2 shows lock; while locked the system bus grant is withdrawn.
// - Bit 3 reads 0 in system reset, 1 out of it.
// - Bit 5 shows whether mass erase is permitted.
// - Bit 6 shows whether the backdoor key is enabled.
// - Bit 7 set when stop mode selects any low-power stop.
// - Bit 8 follows the very-low-power state live, unlatched.
// - Debugger sets erase bit; hardware clears it when erase completes.
module dps_status_port (
   // Clock and reset
   input  wire       clk_sys,
   input  wire       reset,
   // Serial debug link
   input  wire       swd_clk,
   input  wire       swdio_in,
   output reg        swdio_out,
   output reg        swdio_oe,
   // System state sources
   input  wire       sys_reset_active,
   input  wire       flash_init_done,
   input  wire       security_locked,
   input  wire       mass_erase_enable_setting,
   input  wire       backdoor_key_enable,
   input  wire [2:0] stop_mode_select_field,
   input  wire       very_low_power_state,
   // Flash controller handshake
   input  wire       flash_erase_started,
   input  wire       flash_erase_done,
   output reg        flash_erase_req,
   // Bus gating
   output reg        sys_bus_grant
);

   // ----------------------------------------
   // Link framing states
   // ----------------------------------------
   localparam ST_IDLE  = 3'h0;
   localparam ST_REQ   = 3'h1;
   localparam ST_TRN1  = 3'h2;
   localparam ST_ACK   = 3'h3;
   localparam ST_RDATA = 3'h4;
   localparam ST_TRN2  = 3'h5;
   localparam ST_WDATA = 3'h6;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   wire        link_clk_s;
   wire        link_dat_s;
   reg         link_clk_d_reg;
   wire        link_rise;
   reg  [2:0]  state_reg;
   reg  [2:0]  state_next;
   reg  [5:0]  cnt_reg;
   reg  [5:0]  cnt_next;
   reg  [7:0]  req_reg;
   reg  [7:0]  req_next;
   reg  [31:0] shift_reg;
   reg  [31:0] shift_next;
   reg         par_reg;
   reg         par_next;
   reg         out_next;
   reg         oe_next;
   reg         wr_commit;
   wire [7:0]  req_full;
   wire        req_ok;
   wire        req_read;
   wire [1:0]  req_idx;
   reg  [1:0]  idx_reg;
   reg  [1:0]  idx_next;
   reg         rnw_reg;
   reg         rnw_next;
   wire        erase_in_prog;
   wire        erase_ack;
   wire        flash_req_int;
   wire        erase_permitted;
   wire [31:0] status_word;
   wire [31:0] control_word;
   reg  [31:0] read_word;
   wire [2:0]  ack_code;

   // ----------------------------------------
   // Stop mode decode
   // ----------------------------------------
   function lp_stop_selected;
      input [2:0] stopm;
      begin
         lp_stop_selected = (stopm == `DPS_STOPM_VERY_LOW_POWER_STOP) |
                            (stopm == `DPS_STOPM_LLS)  |
                            (stopm == `DPS_STOPM_VLLS);
      end
   endfunction

   // ----------------------------------------
   // Link pin synchronisers
   // ----------------------------------------
   dps_sync #(
      .WIDTH (2)
   ) u_link_sync (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .async_in ({swd_clk, swdio_in}),
      .sync_out ({link_clk_s, link_dat_s})
   );

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         link_clk_d_reg <= 1'b0;
      end else begin
         link_clk_d_reg <= link_clk_s;
      end
   end

   assign link_rise = link_clk_s & ~link_clk_d_reg;

   // ----------------------------------------
   // Mass erase handshake
   // ----------------------------------------
   // Security does not block erase; only the enable setting does
   assign erase_permitted = mass_erase_enable_setting;

   dps_erase_ctl u_erase (
      .clk_sys               (clk_sys),
      .reset                 (reset),
      .sys_reset_active      (sys_reset_active),
      .erase_permitted       (erase_permitted),
      .ctrl_write            (wr_commit),
      .ctrl_erase_bit        (shift_reg[`DPS_CT_ERASE_IN_PROG]),
      .flash_erase_started   (flash_erase_started),
      .flash_erase_done      (flash_erase_done),
      .erase_in_progress_reg (erase_in_prog),
      .erase_ack_reg         (erase_ack),
      .flash_erase_req_reg   (flash_req_int)
   );

   // ----------------------------------------
   // Status and control words
   // ----------------------------------------
   assign status_word = {
      23'h000000,
      very_low_power_state,
      lp_stop_selected(stop_mode_select_field),
      backdoor_key_enable,
      mass_erase_enable_setting,
      1'b0,
      ~sys_reset_active,
      security_locked,
      flash_init_done,
      erase_ack
   };

   assign control_word = {31'h00000000, erase_in_prog};
   assign ack_code     = `DPS_ACK_OK;

   always @* begin
      case (idx_reg)
         `DPS_IDX_STATUS: begin
            read_word = status_word;
         end
         `DPS_IDX_CONTROL: begin
            read_word = control_word;
         end
         default: begin
            read_word = 32'h00000000;
         end
      endcase
   end

   // ----------------------------------------
   // Request decode
   // ----------------------------------------
   // Bits arrive LSB first: start, port, rnw, a2, a3, parity, stop, park
   assign req_full = {link_dat_s, req_reg[7:1]};
   assign req_ok   = req_full[0] & ~req_full[6] & req_full[7] &
                     ~(^req_full[5:1]);
   assign req_read = req_full[2];
   assign req_idx  = req_full[4:3];

   // ----------------------------------------
   // Link framing
   // ----------------------------------------
   // One link bit per sampled rising edge; a malformed request is ignored
   always @* begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      req_next   = req_reg;
      shift_next = shift_reg;
      par_next   = par_reg;
      out_next   = swdio_out;
      oe_next    = swdio_oe;
      idx_next   = idx_reg;
      rnw_next   = rnw_reg;
      wr_commit  = 1'b0;
      if (link_rise) begin
         case (state_reg)
            ST_IDLE: begin
               if (link_dat_s) begin
                  req_next   = {link_dat_s, 7'h00};
                  cnt_next   = 6'h01;
                  state_next = ST_REQ;
               end
            end
            ST_REQ: begin
               req_next = req_full;
               cnt_next = cnt_reg + 6'h01;
               if (cnt_reg == {2'h0, `DPS_REQ_BITS} - 6'h01) begin
                  idx_next   = req_idx;
                  rnw_next   = req_read;
                  state_next = req_ok ? ST_TRN1 : ST_IDLE;
               end
            end
            ST_TRN1: begin
               oe_next    = 1'b1;
               out_next   = ack_code[0];
               cnt_next   = 6'h01;
               state_next = ST_ACK;
            end
            ST_ACK: begin
               if (cnt_reg < `DPS_ACK_BITS) begin
                  out_next = ack_code[cnt_reg[1:0]];
                  cnt_next = cnt_reg + 6'h01;
               end else if (rnw_reg) begin
                  shift_next = {1'b0, read_word[31:1]};
                  par_next   = ^read_word;
                  out_next   = read_word[0];
                  cnt_next   = 6'h01;
                  state_next = ST_RDATA;
               end else begin
                  oe_next    = 1'b0;
                  state_next = ST_TRN2;
               end
            end
            ST_RDATA: begin
               if (cnt_reg < `DPS_DATA_BITS) begin
                  out_next   = shift_reg[0];
                  shift_next = {1'b0, shift_reg[31:1]};
                  cnt_next   = cnt_reg + 6'h01;
               end else if (cnt_reg == `DPS_DATA_BITS) begin
                  out_next = par_reg;
                  cnt_next = cnt_reg + 6'h01;
               end else begin
                  oe_next    = 1'b0;
                  out_next   = 1'b0;
                  state_next = ST_IDLE;
               end
            end
            ST_TRN2: begin
               cnt_next   = 6'h00;
               par_next   = 1'b0;
               state_next = ST_WDATA;
            end
            ST_WDATA: begin
               if (cnt_reg < `DPS_DATA_BITS) begin
                  shift_next = {link_dat_s, shift_reg[31:1]};
                  par_next   = par_reg ^ link_dat_s;
                  cnt_next   = cnt_reg + 6'h01;
               end else begin
                  // Bad parity drops the write; status index never writes
                  wr_commit  = (par_reg == link_dat_s) &
                               (idx_reg == `DPS_IDX_CONTROL);
                  state_next = ST_IDLE;
               end
            end
            default: begin
               oe_next    = 1'b0;
               state_next = ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 6'h00;
         req_reg   <= 8'h00;
         shift_reg <= `DPS_RST_CONTROL;
         par_reg   <= 1'b0;
         idx_reg   <= 2'h0;
         rnw_reg   <= 1'b0;
         swdio_out <= 1'b0;
         swdio_oe  <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         req_reg   <= req_next;
         shift_reg <= shift_next;
         par_reg   <= par_next;
         idx_reg   <= idx_next;
         rnw_reg   <= rnw_next;
         swdio_out <= out_next;
         swdio_oe  <= oe_next;
      end
   end

   // ----------------------------------------
   // Outputs to the system
   // ----------------------------------------
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         flash_erase_req <= 1'b0;
         sys_bus_grant   <= 1'b0;
      end else begin
         flash_erase_req <= flash_req_int;
         sys_bus_grant   <= ~security_locked;
      end
   end

endmodule

`default_nettype wire

// ---- tb/dps_dbg_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Debugger end of the serial link
// ----------------------------------------
module dps_dbg_model (
   // Clock
   input  wire logic clk_sys,
   // Link
   input  wire logic swdio_out,
   input  wire logic swdio_oe,
   output var  logic swd_clk,
   output wire logic swdio_in,
   // Observation
   output var  logic oe_seen
);
   logic dv;
   logic slow;
   // Released line shows a moving value, never the stale one
   assign swdio_in = swdio_oe ? swdio_out : dv;
   initial begin
      swd_clk = 1'b0;
      dv = 1'b0;
      oe_seen = 1'b0;
      slow = 1'b0;
   end
   // One 80 ns bit, 120 ns in very low power; data moves with the falling clock
   // Each phase stays under 7 cycles so the idle checks never see a frame
   task automatic sbit(input logic b, input logic rel, output logic s);
      @(negedge clk_sys);
      swd_clk = 1'b0;
      dv = rel ? ~dv : b;
      repeat (slow ? 6 : 4) @(negedge clk_sys);
      s = swdio_in;
      oe_seen = oe_seen | swdio_oe;
      swd_clk = 1'b1;
      repeat (slow ? 5 : 3) @(negedge clk_sys);
   endtask
   task automatic xfer(input logic rnw, input logic [1:0] idx, input logic [31:0] wd,
                       input logic bad, output logic [2:0] ack, output logic [31:0] rd,
                       output logic rp);
      logic [7:0]  rq;
      logic [32:0] dd;
      logic        s;
      int          i;
      rq = {1'b1, 1'b0, ^{rnw, idx} ^ bad, idx[1], idx[0], rnw, 1'b0, 1'b1};
      oe_seen = 1'b0;
      ack = 3'h0;
      dd = 33'h0;
      for (i = 0; i < 8; i++) sbit(rq[i], 1'b0, s);
      if (!bad) begin
         sbit(1'b0, 1'b1, s);
         for (i = 0; i < 3; i++) begin
            sbit(1'b0, 1'b1, s);
            ack[i] = s;
         end
         if (rnw) begin
            for (i = 0; i < 33; i++) begin
               sbit(1'b0, 1'b1, s);
               dd[i] = s;
            end
         end else begin
            sbit(1'b0, 1'b1, s);
            for (i = 0; i < 33; i++) sbit((i == 32) ? ^wd : wd[i], 1'b0, s);
         end
      end
      // Idle bits let the block settle; then the clock stands still
      for (i = 0; i < 3; i++) sbit(1'b0, 1'b0, s);
      rd = dd[31:0];
      rp = dd[32];
      @(negedge clk_sys);
      swd_clk = 1'b0;
      repeat (10) @(negedge clk_sys);
   endtask
endmodule
`default_nettype wire

// ---- tb/dps_status_port_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module dps_status_port_assertions (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       reset,
   // Link
   input wire logic       swd_clk,
   input wire logic       swdio_in,
   input wire logic       swdio_out,
   input wire logic       swdio_oe,
   // System state
   input wire logic       sys_reset_active,
   input wire logic       flash_init_done,
   input wire logic       security_locked,
   input wire logic       mass_erase_enable_setting,
   input wire logic       backdoor_key_enable,
   input wire logic [2:0] stop_mode_select_field,
   input wire logic       very_low_power_state,
   // Flash handshake and gating
   input wire logic       flash_erase_started,
   input wire logic       flash_erase_done,
   input wire logic       flash_erase_req,
   input wire logic       sys_bus_grant
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   reset_quiet_a: assert property (disable iff (1'b0)
      reset |-> !swdio_oe && !flash_erase_req && !sys_bus_grant) else $error("output active in reset");
   bus_grant_a: assert property (
      !$past(reset) |-> sys_bus_grant == !$past(security_locked)) else $error("grant not lock");
   req_enable_a: assert property (
      flash_erase_req |-> $past(mass_erase_enable_setting)) else $error("request while disabled");
   req_done_a: assert property (
      flash_erase_done |-> ##[1:3] !flash_erase_req) else $error("request after done");
   req_sysrst_a: assert property (
      sys_reset_active |-> ##[1:3] !flash_erase_req) else $error("request after system reset");
   req_steady_a: assert property (
      flash_erase_req && mass_erase_enable_setting && !flash_erase_done && !sys_reset_active
      && !$past(flash_erase_done) && !$past(sys_reset_active) |=> flash_erase_req)
      else $error("request dropped early");
   // A stopped link clock means no frame is open
   link_idle_a: assert property (
      !swd_clk [*8] |-> !swdio_oe) else $error("drive outside frame");
   link_stands_a: assert property (
      $stable(swd_clk) [*7] |-> $stable(swdio_out) && $stable(swdio_oe)) else $error("link moved");
endmodule
bind dps_status_port dps_status_port_assertions u_chk (
   .clk_sys(clk_sys), .reset(reset), .swd_clk(swd_clk), .swdio_in(swdio_in),
   .swdio_out(swdio_out), .swdio_oe(swdio_oe), .sys_reset_active(sys_reset_active),
   .flash_init_done(flash_init_done), .security_locked(security_locked),
   .mass_erase_enable_setting(mass_erase_enable_setting),
   .backdoor_key_enable(backdoor_key_enable), .stop_mode_select_field(stop_mode_select_field),
   .very_low_power_state(very_low_power_state), .flash_erase_started(flash_erase_started),
   .flash_erase_done(flash_erase_done), .flash_erase_req(flash_erase_req),
   .sys_bus_grant(sys_bus_grant));
`default_nettype wire

// ---- tb/dps_status_port_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dps_defines.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
$display("Error at %0t: got %h want %h", $time, (a), (e)); end end
module dps_status_port_tb_top;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic        clk_sys, reset, swd_clk, swdio_in, swdio_out, swdio_oe, oe_seen, par;
   logic        sys_reset_active, flash_init_done, security_locked, sys_bus_grant;
   logic        mass_erase_enable_setting, backdoor_key_enable, very_low_power_state;
   logic        flash_erase_started, flash_erase_done, flash_erase_req;
   logic [2:0]  stop_mode_select_field, ack;
   logic [31:0] d;
   int          miscompares, n_checks, i;
   // Ready, lock, erase en, key en, stop code, vlp, sys reset; then the word
   logic [40:0] rows [8] = '{{9'h100, 32'h0000000a}, {9'h084, 32'h0000000c},
      {9'h148, 32'h000000aa}, {9'h02e, 32'h000001c8}, {9'h1f0, 32'h000000ee},
      {9'h016, 32'h00000108}, {9'h119, 32'h00000002}, {9'h05d, 32'h00000020}};
   dps_status_port dut (
      .clk_sys(clk_sys), .reset(reset), .swd_clk(swd_clk), .swdio_in(swdio_in),
      .swdio_out(swdio_out), .swdio_oe(swdio_oe), .sys_reset_active(sys_reset_active),
      .flash_init_done(flash_init_done), .security_locked(security_locked),
      .mass_erase_enable_setting(mass_erase_enable_setting),
      .backdoor_key_enable(backdoor_key_enable), .stop_mode_select_field(stop_mode_select_field),
      .very_low_power_state(very_low_power_state), .flash_erase_started(flash_erase_started),
      .flash_erase_done(flash_erase_done), .flash_erase_req(flash_erase_req),
      .sys_bus_grant(sys_bus_grant));
   dps_dbg_model u_dbg (
      .clk_sys(clk_sys), .swdio_out(swdio_out), .swdio_oe(swdio_oe), .swd_clk(swd_clk),
      .swdio_in(swdio_in), .oe_seen(oe_seen));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic rd_w(input logic [1:0] idx);
      u_dbg.xfer(1'b1, idx, 32'h0, 1'b0, ack, d, par);
      `CHK(ack, `DPS_ACK_OK)
      `CHK(par, ^d)
   endtask
   task automatic wr_w(input logic [1:0] idx, input logic [31:0] w);
      u_dbg.xfer(1'b0, idx, w, 1'b0, ack, d, par);
      `CHK(ack, `DPS_ACK_OK)
   endtask
   // Bits: system reset, erase done, erase started
   task automatic pulse(input logic [2:0] m);
      @(negedge clk_sys);
      {sys_reset_active, flash_erase_done, flash_erase_started} = m;
      repeat (2) @(negedge clk_sys);
      {sys_reset_active, flash_erase_done, flash_erase_started} = 3'h0;
   endtask
   task automatic stop_test;
      $display("checks %0d, miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ----------------------------------------
   // Clock, watchdog, sequence
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (100000) @(posedge clk_sys);
      miscompares++;
      stop_test;
   end
   initial begin
      reset = 1'b1;
      {sys_reset_active, flash_init_done, security_locked, mass_erase_enable_setting} = 4'h0;
      {backdoor_key_enable, very_low_power_state, flash_erase_started, flash_erase_done} = 4'h0;
      stop_mode_select_field = 3'h0;
      miscompares = 0;
      n_checks = 0;
      repeat (6) @(negedge clk_sys);
      `CHK({swdio_oe, flash_erase_req, sys_bus_grant}, 3'h0)
      reset = 1'b0;
      $display("test reset done");
      for (i = 0; i < 8; i++) begin
         @(negedge clk_sys);
         {flash_init_done, security_locked, mass_erase_enable_setting, backdoor_key_enable,
          stop_mode_select_field, very_low_power_state, sys_reset_active} = rows[i][40:32];
         rd_w(`DPS_IDX_STATUS);
         `CHK(d, rows[i][31:0])
         `CHK(d[7], rows[i][36:34] inside {`DPS_STOPM_VERY_LOW_POWER_STOP, `DPS_STOPM_LLS, `DPS_STOPM_VLLS})
         `CHK(sys_bus_grant, ~security_locked)
         u_dbg.slow = d[8];
      end
      $display("test table done");
      @(negedge clk_sys);
      {flash_init_done, mass_erase_enable_setting, sys_reset_active, security_locked} = 4'hc;
      {backdoor_key_enable, very_low_power_state, stop_mode_select_field} = 5'h00;
      wr_w(`DPS_IDX_STATUS, 32'hffffffff);
      rd_w(`DPS_IDX_STATUS);
      `CHK(d, 32'h0000002a)
      rd_w(2'h2);
      `CHK(d, 32'h00000000)
      $display("test read only done");
      wr_w(`DPS_IDX_CONTROL, 32'h00000001);
      `CHK(flash_erase_req, 1'b1)
      rd_w(`DPS_IDX_STATUS);
      `CHK(d[0], 1'b0)
      pulse(3'h1);
      rd_w(`DPS_IDX_STATUS);
      `CHK(d[0], 1'b1)
      pulse(3'h2);
      rd_w(`DPS_IDX_CONTROL);
      `CHK(d, 32'h00000000)
      `CHK(flash_erase_req, 1'b0)
      // Relaunch must drop the old acknowledge first
      wr_w(`DPS_IDX_CONTROL, 32'h00000001);
      rd_w(`DPS_IDX_STATUS);
      `CHK(d[0], 1'b0)
      pulse(3'h1);
      pulse(3'h4);
      rd_w(`DPS_IDX_STATUS);
      `CHK(d, 32'h0000002a)
      rd_w(`DPS_IDX_CONTROL);
      `CHK(d, 32'h00000000)
      $display("test erase done");
      @(negedge clk_sys);
      mass_erase_enable_setting = 1'b0;
      wr_w(`DPS_IDX_CONTROL, 32'h00000001);
      pulse(3'h1);
      rd_w(`DPS_IDX_STATUS);
      `CHK(d, 32'h0000000a)
      `CHK(flash_erase_req, 1'b0)
      rd_w(`DPS_IDX_CONTROL);
      `CHK(d, 32'h00000001)
      pulse(3'h4);
      rd_w(`DPS_IDX_CONTROL);
      `CHK(d, 32'h00000000)
      $display("test erase disabled done");
      u_dbg.xfer(1'b1, `DPS_IDX_STATUS, 32'h0, 1'b1, ack, d, par);
      `CHK(oe_seen, 1'b0)
      rd_w(`DPS_IDX_STATUS);
      `CHK(d, 32'h0000000a)
      $display("test refused request done");
      // Block reset in mid-run drops a stuck erase bit as well
      wr_w(`DPS_IDX_CONTROL, 32'h00000001);
      @(negedge clk_sys);
      reset = 1'b1;
      repeat (2) @(negedge clk_sys);
      `CHK({swdio_oe, flash_erase_req, sys_bus_grant}, 3'h0)
      reset = 1'b0;
      rd_w(`DPS_IDX_CONTROL);
      `CHK(d, 32'h00000000)
      `CHK(sys_bus_grant, 1'b1)
      $display("test mid reset done");
      stop_test;
   end
endmodule
`default_nettype wire
